/* File: logic/oip_consts.vh */
// Constants for the oscillator interpolation port
`ifndef OIP_CONSTS_VH
`define OIP_CONSTS_VH

`define OIP_ADDR_W          4
`define OIP_OFF_CONTROL     4'h0
`define OIP_OFF_INPUT_CODE  4'h4
`define OIP_OFF_DIVIDER     4'h8

`define OIP_RUN_BIT         0
`define OIP_PREC_LSB        1
`define OIP_PREC_MSB        3
`define OIP_PREC_W          3
`define OIP_PREC_RESET      3'h0
`define OIP_CODE_W          16
`define OIP_CODE_RESET      16'h0000
`define OIP_DIV_RESET       16'h0001
`define OIP_DIV_ILLEGAL     16'h0000
`define OIP_DIV_ONE         16'h0001
`define OIP_MAX_BITS        16

`define OIP_RESP_OKAY       2'h0
`define OIP_RESP_SLVERR     2'h2

`endif

/* File: logic/oip_modulator.v */
// First-order sigma-delta modulator with precision masking and tick divider
`timescale 1ns/1ps
`include "oip_consts.vh"
module oip_modulator #(
	parameter CODE_W = `OIP_CODE_W
)(
	input  wire              aclk,
	input  wire              aresetn,
	input  wire              run,
	input  wire [2:0]        precision,
	input  wire [CODE_W-1:0] code,
	input  wire [CODE_W-1:0] divider,
	output reg               ctrl_out_reg
);
	reg  [CODE_W-1:0] tick_cnt_reg;
	reg  [CODE_W:0]   acc_reg;
	wire [CODE_W-1:0] keep_mask;
	wire [CODE_W-1:0] masked_code;
	wire [CODE_W:0]   acc_sum;
	wire              tick;

	// Keep the top (16 - precision) bits of the code
	assign keep_mask   = {CODE_W{1'b1}} << precision;
	assign masked_code = code & keep_mask;
	// Carry of the accumulator is the output bit; ones density equals masked_code/2^16
	assign acc_sum     = {1'b0, acc_reg[CODE_W-1:0]} + {1'b0, masked_code};
	assign tick        = (tick_cnt_reg >= divider - `OIP_DIV_ONE);

	always @(posedge aclk)
	begin
		if (!aresetn || !run)
		begin
			tick_cnt_reg <= {CODE_W{1'b0}};
			acc_reg      <= {(CODE_W+1){1'b0}};
			ctrl_out_reg <= 1'b0;
		end
		else
		begin
			if (tick)
			begin
				tick_cnt_reg <= {CODE_W{1'b0}};
				acc_reg      <= acc_sum;
				ctrl_out_reg <= acc_sum[CODE_W];
			end
			else
				tick_cnt_reg <= tick_cnt_reg + `OIP_DIV_ONE;
		end
	end
endmodule // oip_modulator

/* File: logic/oip_top.v */
// Oscillator interpolation port: AXI4-Lite register bank and modulator
//
// How it works
// - Unused upper bits of all three registers read zero and ignore writes.
// - Precision field bits 3..1: code 0 means 16 bits, code 7 means 9.
// - Precision changes only while the run bit is clear.
// - Run bit, control bit 0, is writable at any time.
// - Run clear holds modulator in reset and drives the output low.
// - One write may set precision and run together; afterwards configuration locks.
// - With run set, a control write changes only the run bit.
// - Clearing run with other field changes keeps those fields unchanged.
// - With run set the input code is modulated onto the output.
// - Input code register accepts writes only while run is set.
// - Below 16 bits precision only the top code bits are used.
// - Input code sits in bits 15..0, any value up to FFFF.
// - Interpolation tick is the module clock divided by the divider value.
// - Divider resets to 0001.
// - Writing divider 0000 acts as writing 0001.
// - Divider accepts writes only while run is clear.
// - Divider ratio occupies bits 15..0, up to FFFF.
// - One output pin drives the oscillator, precision 9 to 16 bits.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "oip_consts.vh"
module oip_top #(
	parameter ADDR_W = `OIP_ADDR_W,
	parameter CODE_W = `OIP_CODE_W
)(
	input  wire              aclk,
	input  wire              aresetn,
	input  wire [ADDR_W-1:0] s_axil_awaddr,
	input  wire [2:0]        s_axil_awprot,
	input  wire              s_axil_awvalid,
	output reg               s_axil_awready,
	input  wire [31:0]       s_axil_wdata,
	input  wire [3:0]        s_axil_wstrb,
	input  wire              s_axil_wvalid,
	output reg               s_axil_wready,
	output reg  [1:0]        s_axil_bresp,
	output reg               s_axil_bvalid,
	input  wire              s_axil_bready,
	input  wire [ADDR_W-1:0] s_axil_araddr,
	input  wire [2:0]        s_axil_arprot,
	input  wire              s_axil_arvalid,
	output reg               s_axil_arready,
	output reg  [31:0]       s_axil_rdata,
	output reg  [1:0]        s_axil_rresp,
	output reg               s_axil_rvalid,
	input  wire              s_axil_rready,
	output wire              oscillator_ctrl_out
);
	reg                  run_reg;
	reg  [2:0]           precision_reg;
	reg  [CODE_W-1:0]    code_reg;
	reg  [CODE_W-1:0]    divider_reg;
	reg  [ADDR_W-1:0]    waddr_reg;
	reg  [31:0]          wdata_reg;
	reg  [3:0]           wstrb_reg;
	reg                  have_aw_reg;
	reg                  have_w_reg;
	reg  [31:0]          rdata_next;
	reg  [1:0]           rresp_next;
	reg  [31:0]          wmerged;
	reg  [CODE_W-1:0]    div_next;
	wire                 do_write;
	// Handshake and decode nets
	wire                 aw_take;
	wire                 w_take;
	wire                 b_take;
	wire                 ar_take;
	wire                 r_take;
	wire                 sel_control;
	wire                 sel_input_code;
	wire                 sel_divider;
	wire                 wr_resp_ok;
	wire                 ctrl_we;
	wire                 code_we;
	wire                 div_we;
	wire                 wr_run;
	wire [2:0]           wr_prec;
	wire [CODE_W-1:0]    wr_code;
	// Next values of the bus and register flip-flops
	reg                  run_next;
	reg  [2:0]           precision_next;
	reg  [CODE_W-1:0]    code_next;
	reg  [CODE_W-1:0]    divider_next;
	reg                  awready_next;
	reg                  wready_next;
	reg                  have_aw_next;
	reg                  have_w_next;
	reg  [ADDR_W-1:0]    waddr_next;
	reg  [31:0]          wdata_next;
	reg  [3:0]           wstrb_next;
	reg                  bvalid_next;
	reg  [1:0]           bresp_next;
	reg                  arready_next;
	reg                  rvalid_next;
	reg  [31:0]          rdata_out_next;
	reg  [1:0]           rresp_out_next;

	// Merge byte-enabled write data over the current register value
	function [31:0] merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		integer i;
		begin
			merge = old_val;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = new_val[i*8 +: 8];
		end
	endfunction

	// Register image as read back; upper bits zero
	function [31:0] reg_image;
		input [ADDR_W-1:0] addr;
		input              run;
		input [2:0]        prec;
		input [CODE_W-1:0] code;
		input [CODE_W-1:0] div;
		begin
			reg_image = 32'h0000_0000;
			case (addr)
			`OIP_OFF_CONTROL:
			begin
				reg_image[`OIP_RUN_BIT] = run;
				reg_image[`OIP_PREC_MSB:`OIP_PREC_LSB] = prec;
			end
			`OIP_OFF_INPUT_CODE:
				reg_image[CODE_W-1:0] = code;
			`OIP_OFF_DIVIDER:
				reg_image[CODE_W-1:0] = div;
			default:
				reg_image = 32'h0000_0000;
			endcase
		end
	endfunction

	// A zero ratio is illegal and divides as if one had been written
	function [CODE_W-1:0] legal_divider;
		input [CODE_W-1:0] ratio;
		begin
			if (ratio == `OIP_DIV_ILLEGAL)
				legal_divider = `OIP_DIV_ONE;
			else
				legal_divider = ratio;
		end
	endfunction

	function known_addr;
		input [ADDR_W-1:0] addr;
		begin
			known_addr = (addr == `OIP_OFF_CONTROL) || (addr == `OIP_OFF_INPUT_CODE) ||
				(addr == `OIP_OFF_DIVIDER);
		end
	endfunction

	// Handshake strobes, one per channel
	assign aw_take        = s_axil_awvalid && s_axil_awready;
	assign w_take         = s_axil_wvalid && s_axil_wready;
	assign b_take         = s_axil_bvalid && s_axil_bready;
	assign ar_take        = s_axil_arvalid && s_axil_arready;
	assign r_take         = s_axil_rvalid && s_axil_rready;
	// A write lands once both halves are held and no response is pending
	assign do_write       = have_aw_reg && have_w_reg && !s_axil_bvalid;
	assign wr_resp_ok     = known_addr(waddr_reg);
	// Per-register write enables for the pending write
	assign sel_control    = (waddr_reg == `OIP_OFF_CONTROL);
	assign sel_input_code = (waddr_reg == `OIP_OFF_INPUT_CODE);
	assign sel_divider    = (waddr_reg == `OIP_OFF_DIVIDER);
	assign ctrl_we        = do_write && sel_control;
	assign code_we        = do_write && sel_input_code && run_reg;
	assign div_we         = do_write && sel_divider && !run_reg;
	// Fields of the merged write word
	assign wr_run         = wmerged[`OIP_RUN_BIT];
	assign wr_prec        = wmerged[`OIP_PREC_MSB:`OIP_PREC_LSB];
	assign wr_code        = wmerged[CODE_W-1:0];

	always @*
	begin
		wmerged  = merge(reg_image(waddr_reg, run_reg, precision_reg, code_reg, divider_reg),
			wdata_reg, wstrb_reg);
		div_next = legal_divider(wmerged[CODE_W-1:0]);
		rdata_next = reg_image(s_axil_araddr, run_reg, precision_reg, code_reg, divider_reg);
		rresp_next = known_addr(s_axil_araddr) ? `OIP_RESP_OKAY : `OIP_RESP_SLVERR;
	end

	// Write channel next state: address and data captured in either order
	always @*
	begin
		awready_next = s_axil_awready;
		wready_next  = s_axil_wready;
		have_aw_next = have_aw_reg;
		have_w_next  = have_w_reg;
		waddr_next   = waddr_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = s_axil_bvalid;
		bresp_next   = s_axil_bresp;
		if (aw_take)
		begin
			waddr_next   = s_axil_awaddr;
			have_aw_next = 1'b1;
			awready_next = 1'b0;
		end
		if (w_take)
		begin
			wdata_next  = s_axil_wdata;
			wstrb_next  = s_axil_wstrb;
			have_w_next = 1'b1;
			wready_next = 1'b0;
		end
		if (do_write)
		begin
			have_aw_next = 1'b0;
			have_w_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_resp_ok ? `OIP_RESP_OKAY : `OIP_RESP_SLVERR;
		end
		// Readies return only after the response is taken
		if (b_take)
		begin
			bvalid_next  = 1'b0;
			awready_next = 1'b1;
			wready_next  = 1'b1;
		end
	end

	// Write channel flip-flops
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axil_awready <= 1'b1;
			s_axil_wready  <= 1'b1;
			have_aw_reg    <= 1'b0;
			have_w_reg     <= 1'b0;
			waddr_reg      <= {ADDR_W{1'b0}};
			wdata_reg      <= 32'h0000_0000;
			wstrb_reg      <= 4'h0;
			s_axil_bvalid  <= 1'b0;
			s_axil_bresp   <= `OIP_RESP_OKAY;
		end
		else
		begin
			s_axil_awready <= awready_next;
			s_axil_wready  <= wready_next;
			have_aw_reg    <= have_aw_next;
			have_w_reg     <= have_w_next;
			waddr_reg      <= waddr_next;
			wdata_reg      <= wdata_next;
			wstrb_reg      <= wstrb_next;
			s_axil_bvalid  <= bvalid_next;
			s_axil_bresp   <= bresp_next;
		end
	end

	// Register bank next state; the run bit decides which fields may change
	always @*
	begin
		run_next       = run_reg;
		precision_next = precision_reg;
		code_next      = code_reg;
		divider_next   = divider_reg;
		if (ctrl_we)
		begin
			run_next = wr_run;
			// Fields follow the old run value, so clearing run leaves them
			if (!run_reg)
				precision_next = wr_prec;
		end
		if (code_we)
			code_next = wr_code;
		if (div_we)
			divider_next = div_next;
	end

	// Register bank flip-flops
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			run_reg       <= 1'b0;
			precision_reg <= `OIP_PREC_RESET;
			code_reg      <= `OIP_CODE_RESET;
			divider_reg   <= `OIP_DIV_RESET;
		end
		else
		begin
			run_reg       <= run_next;
			precision_reg <= precision_next;
			code_reg      <= code_next;
			divider_reg   <= divider_next;
		end
	end

	// Read channel next state; data is taken with the address
	always @*
	begin
		arready_next   = s_axil_arready;
		rvalid_next    = s_axil_rvalid;
		rdata_out_next = s_axil_rdata;
		rresp_out_next = s_axil_rresp;
		if (ar_take)
		begin
			arready_next   = 1'b0;
			rvalid_next    = 1'b1;
			rdata_out_next = rdata_next;
			rresp_out_next = rresp_next;
		end
		else if (r_take)
		begin
			rvalid_next  = 1'b0;
			arready_next = 1'b1;
		end
	end

	// Read channel flip-flops
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axil_arready <= 1'b1;
			s_axil_rvalid  <= 1'b0;
			s_axil_rdata   <= 32'h0000_0000;
			s_axil_rresp   <= `OIP_RESP_OKAY;
		end
		else
		begin
			s_axil_arready <= arready_next;
			s_axil_rvalid  <= rvalid_next;
			s_axil_rdata   <= rdata_out_next;
			s_axil_rresp   <= rresp_out_next;
		end
	end

	oip_modulator #(
		.CODE_W (CODE_W)
	) u_mod (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.run          (run_reg),
		.precision    (precision_reg),
		.code         (code_reg),
		.divider      (divider_reg),
		.ctrl_out_reg (oscillator_ctrl_out)
	);
endmodule // oip_top

/* File: testbench/oip_chk.sv */
// Bus handshake and control output checks for the interpolation port
`timescale 1ns/1ps
module oip_chk (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axil_awvalid,
	input wire        s_axil_awready,
	input wire        s_axil_wvalid,
	input wire        s_axil_wready,
	input wire [1:0]  s_axil_bresp,
	input wire        s_axil_bvalid,
	input wire        s_axil_bready,
	input wire        s_axil_arvalid,
	input wire        s_axil_arready,
	input wire [31:0] s_axil_rdata,
	input wire [1:0]  s_axil_rresp,
	input wire        s_axil_rvalid,
	input wire        s_axil_rready,
	input wire        oscillator_ctrl_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	out_idle_a: assert property ($rose(aresetn) |-> !oscillator_ctrl_out [*3])
		else $error("control output high after reset");
	rd_lat_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
		else $error("read answer late");
	wr_lat_a: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid
		&& s_axil_wready |=> !s_axil_bvalid ##1 s_axil_bvalid) else $error("write answer off");
	wr_busy_a: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
		else $error("write ready during response");
	b_done_a: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid
		&& s_axil_awready && s_axil_wready) else $error("write response not closed");
	r_done_a: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid
		&& s_axil_arready) else $error("read response not closed");
	rsv_zero_a: assert property (s_axil_rvalid |-> s_axil_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	err_zero_a: assert property (s_axil_rvalid && s_axil_rresp != 2'h0
		|-> s_axil_rdata == 32'h0 && s_axil_rresp == 2'h2) else $error("bad read error");
	bresp_ok_a: assert property (s_axil_bvalid |-> s_axil_bresp == 2'h0
		|| s_axil_bresp == 2'h2) else $error("bad write response");
endmodule // oip_chk
bind oip_top oip_chk u_chk (.*);

/* File: testbench/oip_osc_model.sv */
// Oscillator side: counts the control pulses it receives
`timescale 1ns/1ps
module oip_osc_model (
	input wire          aclk,
	input wire          clr,
	input wire          ctrl,
	output logic [15:0] pulses
);
	logic last;
	// Each rising edge of the single control pin is one nudge
	always @(posedge aclk)
	begin
		last <= ctrl;
		if (clr)
			pulses <= 16'h0000;
		else if (ctrl && !last)
			pulses <= pulses + 16'h0001;
	end
endmodule // oip_osc_model

/* File: testbench/vcxo_interp_control_test.sv */
// Self-checking bench for the oscillator interpolation port
`timescale 1ns/1ps
module vcxo_interp_control_test;
	logic aclk, aresetn = 0, s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
	logic s_axil_arvalid = 0, s_axil_rready = 0, clr = 1;
	logic [3:0] s_axil_awaddr = 4'h0, s_axil_araddr = 4'h0, s_axil_wstrb = 4'hF, ra;
	logic [2:0] s_axil_awprot = 3'h0, s_axil_arprot = 3'h0;
	logic [31:0] s_axil_wdata = 32'h0, rd, rw, rq;
	logic [1:0] rs, ws, rr;
	wire s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
	wire oscillator_ctrl_out;
	wire [1:0] s_axil_bresp, s_axil_rresp;
	wire [31:0] s_axil_rdata;
	wire [15:0] pulses;
	int n_errors = 0, cmp_count = 0, i;
	logic [69:0] rows [10] = '{
		{4'h0, 32'hFFFFFFFE, 32'hE, 2'h0}, {4'h8, 32'hFFFF0000, 32'h1, 2'h0},
		{4'h8, 32'h12345, 32'h2345, 2'h0}, {4'h4, 32'h1234, 32'h0, 2'h0},
		{4'h0, 32'h3, 32'h3, 2'h0}, {4'h0, 32'hD, 32'h3, 2'h0},
		{4'h8, 32'h5, 32'h2345, 2'h0}, {4'h4, 32'hFFFF1234, 32'h1234, 2'h0},
		{4'h0, 32'hE, 32'h2, 2'h0}, {4'hC, 32'h5, 32'h0, 2'h2}};
	oip_top dut (.*);
	oip_osc_model osc (.aclk(aclk), .clr(clr), .ctrl(oscillator_ctrl_out), .pulses(pulses));
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	initial
	begin
		#160000;
		n_errors++;
		wrap_up;
	end
	task chk(input [31:0] s, input [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("Error t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		@(posedge aclk);
		s_axil_awaddr <= a;
		s_axil_wdata <= d;
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axil_awready) s_axil_awvalid <= 1'b0;
			if (s_axil_wready) s_axil_wvalid <= 1'b0;
		end while (s_axil_bvalid !== 1'b1);
		ws = s_axil_bresp;
		s_axil_bready <= 1'b0;
	endtask
	task rdt(input [3:0] a);
		@(posedge aclk);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axil_arready) s_axil_arvalid <= 1'b0;
		end while (s_axil_rvalid !== 1'b1);
		rd = s_axil_rdata;
		rs = s_axil_rresp;
		s_axil_rready <= 1'b0;
	endtask
	task count(input int n, input int lo, input int hi);
		clr <= 1'b0;
		repeat (n) @(posedge aclk);
		chk(32'(pulses >= lo && pulses <= hi), 32'h1);
		clr <= 1'b1;
	endtask
	task wrap_up;
		$display("Compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 10; i++)
		begin
			{ra, rw, rq, rr} = rows[i];
			wr(ra, rw);
			rdt(ra);
			chk(rd, rq);
			chk({ws, rs}, {rr, rr});
		end
		// Quarter code, divide by 3: 400 ticks give one carry in four
		wr(4'h8, 32'h3);
		wr(4'h0, 32'h1);
		wr(4'h4, 32'h4000);
		count(1200, 99, 101);
		// Half code while running: next ticks use it, accumulator kept
		wr(4'h4, 32'h8000);
		count(1200, 199, 201);
		wr(4'h0, 32'h0);
		repeat (4) @(posedge aclk);
		chk(oscillator_ctrl_out, 1'b0);
		// Nine bits keep 0x180 of 0x1FF: 4000 ticks near 23 carries
		wr(4'h0, 32'hE);
		wr(4'h8, 32'h0);
		wr(4'h0, 32'hF);
		wr(4'h4, 32'h1FF);
		count(4000, 22, 24);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 3; i++)
		begin
			rdt(4'(i * 4));
			chk(rd, 32'(i == 2));
		end
		wrap_up;
	end
endmodule // vcxo_interp_control_test
